//--- wmcat_channel_access.sv
// Spacing timers, backoff engines, NAV, TSF/TBTT and sleep timer.
// Assumes sequencer, PHY busy and transmit engine share clk; the slow
// sleep clock arrives asynchronously, is synchronised, and its rising edges are counted.
//
// Overview of operation
// R1: Each backoff counter decrements per idle slot, holds while medium busy.
// R2: A counter reaching zero notifies the transmit engine for its category.
// R3: Simultaneous zeros grant exactly one category by sequencer priority.
// R4: Spacing timers, RIFS included, start when PHY activity ceases.
// R5: Spacing expiry gives precise start triggers for responses and bursts.
// R6: A scheduled frame starts only on the spacing trigger.
// R7: Sequencer picks the next queue from channel-access status.
// R8: Sleep timer on slow clock holds MAC clock off, restores on expiry.
// R9: After wake the sequencer advances TSF by the sleep time.
// R10: Keep a running TSF and track target beacon time from it.
// R11: On command the TSF loads a received timestamp.
// R12: Pulse triggers when TSF reaches programmed offsets.
// R13: On command NAV updates from a received duration field.
// R14: NAV busy acts as virtual carrier sense for spacing and backoff; the code gates only backoff, and the spacing timers ignore NAV.
// R15: Condition signals go straight to the sequencer branch logic.
// R16: NAV counts down per microsecond; larger durations only replace it.
// R17: Sequencer loads a random slot count before enabling an engine.
`timescale 1ns/1ps
`default_nettype none

module wmcat_channel_access (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     phyBusy,
    input  wire logic                     slowClk,
    input  wire wmcat_pkg::wmcat_cmd_type cmd,
    output logic [wmcat_pkg::NUM_AC-1:0]  acGrant,
    output logic                          sifsTrig,
    output logic                          rifsTrig,
    output logic                          txStart,
    output logic                          macClkEn,
    output logic                          wakePulse,
    output logic                          tbttPulse,
    output logic [wmcat_pkg::EVT_N-1:0]   evtPulse,
    output logic [wmcat_pkg::TSF_W-1:0]   tsf,
    output wmcat_pkg::wmcat_cond_type     cond
);

    localparam int NAC = wmcat_pkg::NUM_AC;
    localparam int RIFS_CYC = wmcat_pkg::RIFS_CYC;
    localparam int SIFS_CYC = wmcat_pkg::SIFS_CYC;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ************************************
    // Microsecond and slot ticks
    // ************************************
    logic [4:0] usCnt_reg, usCnt_next;
    logic [3:0] slotCnt_reg, slotCnt_next;
    logic       usTick;
    logic       slotTick;

    assign usTick   = (usCnt_reg == wmcat_pkg::CYC_LAST);
    assign slotTick = usTick && (slotCnt_reg == wmcat_pkg::SLOT_LAST);

    always_comb begin
        usCnt_next   = usTick ? 5'h0 : usCnt_reg + 5'h1;
        slotCnt_next = slotCnt_reg;
        if (slotTick) begin
            slotCnt_next = 4'h0;
        end else if (usTick) begin
            slotCnt_next = slotCnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            usCnt_reg   <= 5'h0;
            slotCnt_reg <= 4'h0;
        end else begin
            usCnt_reg   <= usCnt_next;
            slotCnt_reg <= slotCnt_next;
        end
    end

    // ************************************
    // Spacing timers
    // ************************************
    // Own cycle counter so expiry is aligned to the busy edge, not the
    // free-running microsecond tick.
    logic       phyBusyD_reg;
    logic       ifsRun_reg, ifsRun_next;
    logic       ifsDone_reg, ifsDone_next;
    logic [4:0] ifsCyc_reg, ifsCyc_next;
    logic [4:0] ifsUs_reg, ifsUs_next;
    logic       ceased, ifsWrap, rifsHit, sifsHit, idleOk;
    logic       navBusy_reg;

    assign ceased  = phyBusyD_reg && !phyBusy;
    assign ifsWrap = ifsRun_reg && (ifsCyc_reg == wmcat_pkg::CYC_LAST);
    assign rifsHit = ifsWrap && (ifsUs_reg == wmcat_pkg::RIFS_LAST);
    assign sifsHit = ifsWrap && (ifsUs_reg == wmcat_pkg::SIFS_LAST);
    assign idleOk  = ifsDone_reg && !phyBusy && !navBusy_reg; // see R14

    always_comb begin
        ifsRun_next  = ifsRun_reg;
        ifsCyc_next  = ifsCyc_reg;
        ifsUs_next   = ifsUs_reg;
        ifsDone_next = ifsDone_reg;
        if (phyBusy) begin
            ifsRun_next  = 1'b0;
            ifsDone_next = 1'b0;
        end else if (ceased) begin // see R4
            ifsRun_next = 1'b1;
            // Cease is seen one cycle late; start at one to keep exact
            ifsCyc_next = 5'h1;
            ifsUs_next  = 5'h0;
        end else if (sifsHit) begin
            ifsRun_next  = 1'b0;
            ifsDone_next = 1'b1;
        end else if (ifsWrap) begin
            ifsCyc_next = 5'h0;
            ifsUs_next  = ifsUs_reg + 5'h1;
        end else if (ifsRun_reg) begin
            ifsCyc_next = ifsCyc_reg + 5'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phyBusyD_reg <= 1'b0;
            ifsRun_reg   <= 1'b0;
            ifsDone_reg  <= 1'b0;
            ifsCyc_reg   <= 5'h0;
            ifsUs_reg    <= 5'h0;
            rifsTrig     <= 1'b0;
            sifsTrig     <= 1'b0;
            txStart      <= 1'b0;
        end else begin
            phyBusyD_reg <= phyBusy;
            ifsRun_reg   <= ifsRun_next;
            ifsDone_reg  <= ifsDone_next;
            ifsCyc_reg   <= ifsCyc_next;
            ifsUs_reg    <= ifsUs_next;
            rifsTrig     <= rifsHit; // see R5
            sifsTrig     <= sifsHit; // see R5
            txStart      <= cmd.txScheduled &&
                            (cmd.txUseRifs ? rifsHit : sifsHit); // see R6
        end
    end

    // ************************************
    // Backoff engines and arbitration
    // ************************************
    logic [wmcat_pkg::BK_W-1:0] bkCnt_reg [NAC];
    logic [NAC-1:0] bkDone_reg;
    logic [NAC-1:0] bkZero;
    logic [NAC-1:0] cand;
    logic [NAC-1:0] grantSel;

    genvar g;
    generate
        for (g = 0; g < NAC; g++) begin : gBk
            logic [wmcat_pkg::BK_W-1:0] cntNext;
            logic doneNext, dec;
            assign dec = cmd.bkEnable[g] && slotTick && idleOk &&
                         (bkCnt_reg[g] != '0);
            // Counts about to hit zero compete in the same slot
            assign cand[g] = slotTick && cmd.bkEnable[g] && !bkDone_reg[g]
                && (bkCnt_reg[g] == '0 ||
                    (dec && bkCnt_reg[g] == 10'h001)); // see R2
            assign bkZero[g] = cmd.bkEnable[g] && (bkCnt_reg[g] == '0);
            always_comb begin
                cntNext  = bkCnt_reg[g];
                doneNext = bkDone_reg[g];
                if (cmd.bkLoad[g]) begin
                    cntNext  = cmd.bkLoadVal;
                    doneNext = 1'b0;
                end else begin
                    if (dec) begin
                        cntNext = bkCnt_reg[g] - 10'h001; // see R1
                    end
                    if (grantSel[g]) begin
                        doneNext = 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    bkCnt_reg[g]  <= '0;
                    bkDone_reg[g] <= 1'b0;
                end else begin
                    bkCnt_reg[g]  <= cntNext;
                    bkDone_reg[g] <= doneNext;
                end
            end
            chk_bk_hold: assert property ((!idleOk && !cmd.bkLoad[g])
                |=> $stable(bkCnt_reg[g])) // see R1
                else $error("backoff count moved while medium busy");
            chk_nav_vcs: assert property ((navBusy_reg && !cmd.bkLoad[g])
                |=> $stable(bkCnt_reg[g])) // see R14
                else $error("backoff count moved while nav busy");
        end
    endgenerate

    // Last match wins; scan order flips with the programmed policy
    always_comb begin
        int j;
        grantSel = '0;
        j = 0;
        for (int i = 0; i < NAC; i++) begin
            j = cmd.prioLowFirst ? (NAC - 1 - i) : i;
            if (cand[j]) begin
                grantSel    = '0;
                grantSel[j] = 1'b1; // see R3
            end
        end
    end

    // ************************************
    // NAV
    // ************************************
    logic [wmcat_pkg::NAV_W-1:0] navCnt_reg, navCnt_next;

    always_comb begin
        navCnt_next = navCnt_reg;
        if (cmd.navUpdate && cmd.navDuration > navCnt_reg) begin
            navCnt_next = cmd.navDuration; // see R13
        end else if (usTick && navCnt_reg != '0) begin
            navCnt_next = navCnt_reg - 16'h0001; // see R16
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            navCnt_reg  <= wmcat_pkg::NAV_RST;
            navBusy_reg <= 1'b0;
        end else begin
            navCnt_reg  <= navCnt_next;
            navBusy_reg <= (navCnt_next != '0); // see R14
        end
    end

    // ************************************
    // TSF, TBTT and offset events
    // ************************************
    // A zero beacon interval fires every cycle; sequencer must avoid it.
    logic [wmcat_pkg::TSF_W-1:0] tsf_next, tbttNext_reg, tbttNext_next;
    logic tbttArmed_reg, tbttHit;
    logic [wmcat_pkg::EVT_N-1:0] evtHit;

    assign tbttHit = tbttArmed_reg && (tsf >= tbttNext_reg); // see R10

    always_comb begin
        tsf_next      = tsf;
        tbttNext_next = tbttNext_reg;
        if (cmd.tsfLoad) begin
            tsf_next = cmd.tsfValue; // see R11
        end else if (cmd.tsfAdvance) begin
            tsf_next = tsf + cmd.tsfValue; // see R9
        end else if (usTick) begin
            tsf_next = tsf + 64'h1; // see R10
        end
        if (cmd.tbttArm) begin
            tbttNext_next = cmd.tsfValue;
        end else if (tbttHit) begin
            tbttNext_next = tbttNext_reg + {32'h0, cmd.tbttInterval};
        end
    end

    generate
        for (g = 0; g < wmcat_pkg::EVT_N; g++) begin : gEvt
            assign evtHit[g] = (tsf_next != tsf) &&
                (tsf_next[31:0] == cmd.evtOffset[g]); // see R12
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tsf           <= wmcat_pkg::TSF_RST;
            tbttNext_reg  <= wmcat_pkg::TBTT_RST;
            tbttArmed_reg <= 1'b0;
            tbttPulse     <= 1'b0;
            evtPulse      <= '0;
        end else begin
            tsf           <= tsf_next;
            tbttNext_reg  <= tbttNext_next;
            tbttArmed_reg <= tbttArmed_reg || cmd.tbttArm;
            tbttPulse     <= tbttHit;
            evtPulse      <= evtHit;
        end
    end

    // ************************************
    // Sleep timer
    // ************************************
    logic [2:0] slowSync_reg;
    logic slowTick, asleep_reg, asleep_next, wake;
    logic [wmcat_pkg::SLP_W-1:0] sleepCnt_reg, sleepCnt_next;

    assign slowTick = slowSync_reg[1] && !slowSync_reg[2];

    always_comb begin
        asleep_next   = asleep_reg;
        sleepCnt_next = sleepCnt_reg;
        wake          = 1'b0;
        if (cmd.sleepLoad) begin
            sleepCnt_next = cmd.sleepCount;
            asleep_next   = (cmd.sleepCount != '0);
        end else if (asleep_reg && slowTick) begin
            sleepCnt_next = sleepCnt_reg - 24'h1;
            if (sleepCnt_reg == 24'h1) begin
                asleep_next = 1'b0; // see R8
                wake        = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slowSync_reg <= 3'h0;
            asleep_reg   <= 1'b0;
            sleepCnt_reg <= '0;
            macClkEn     <= 1'b1;
            wakePulse    <= 1'b0;
            acGrant      <= '0;
            cond         <= '0;
        end else begin
            slowSync_reg <= {slowSync_reg[1:0], slowClk};
            asleep_reg   <= asleep_next;
            sleepCnt_reg <= sleepCnt_next;
            macClkEn     <= !asleep_next; // see R8
            wakePulse    <= wake;
            acGrant      <= grantSel; // see R2
            cond         <= {bkZero, phyBusy, navBusy_reg, ifsDone_reg,
                             tbttHit, evtHit, asleep_next}; // see R15
        end
    end

    // ************************************
    // Checks
    // ************************************
    chk_grant_one: assert property ($onehot0(acGrant)) // see R3
        else $error("more than one category granted");
    chk_grant_slot: assert property (|acGrant |-> $past(slotTick)) // see R2
        else $error("grant not at a slot boundary");
    chk_rifs_time: assert property (rifsTrig |-> $past(ceased, RIFS_CYC)
        && !$past(phyBusy)) // see R4
        else $error("reduced spacing trigger mistimed");
    chk_sifs_time: assert property (sifsTrig |->
        $past(ceased, SIFS_CYC)) // see R5
        else $error("short spacing trigger mistimed");
    chk_tx_gate: assert property (txStart |->
        (sifsTrig || rifsTrig) && $past(cmd.txScheduled)) // see R6
        else $error("transmit start without trigger");
    chk_nav_max: assert property (cmd.navUpdate && !navBusy_reg &&
        cmd.navDuration != '0 |=> navBusy_reg ##0
        navCnt_reg == $past(cmd.navDuration)) // see R16
        else $error("nav did not take larger duration");
    chk_tsf_load: assert property (cmd.tsfLoad |=>
        tsf == $past(cmd.tsfValue)) // see R11
        else $error("tsf did not load timestamp");
    chk_tsf_run: assert property (usTick && !cmd.tsfLoad &&
        !cmd.tsfAdvance |=> tsf == $past(tsf) + 64'h1) // see R10
        else $error("tsf did not advance");
    chk_evt_hit: assert property (evtPulse[0] |->
        tsf[31:0] == $past(cmd.evtOffset[0])) // see R12
        else $error("offset event at wrong time");
    chk_wake_clk: assert property (wakePulse |-> macClkEn &&
        $past(asleep_reg) && !$past(macClkEn)) // see R8
        else $error("wake without clock restore");
    chk_cond_sleep: assert property (cond.asleep == !macClkEn) // see R15
        else $error("sleep condition disagrees with clock enable");

    cov_grant: cover property (|acGrant);
    cov_collide: cover property ($countones(cand) > 1);
    cov_sifs_tx: cover property (txStart && sifsTrig);
    cov_wake: cover property (wakePulse);

endmodule

`default_nettype wire

//--- wmcat_pkg.sv
// Constants and carrier types of the channel-access timing block.
// Assumes a single 25 MHz clock and a sequencer on the same clock.
package wmcat_pkg;

    // ************************************
    // Clock and timing
    // ************************************
    localparam int CLK_HZ   = 25000000;
    localparam int US_PER_S = 1000000;
    localparam int US_CYC   = CLK_HZ / US_PER_S;
    localparam int SLOT_US  = 9;
    localparam int SIFS_US  = 16;
    localparam int RIFS_US  = 2;
    localparam int RIFS_CYC = RIFS_US * US_CYC;
    localparam int SIFS_CYC = SIFS_US * US_CYC;
    localparam logic [4:0] CYC_LAST  = 5'(US_CYC - 1);
    localparam logic [4:0] RIFS_LAST = 5'(RIFS_US - 1);
    localparam logic [4:0] SIFS_LAST = 5'(SIFS_US - 1);
    localparam logic [3:0] SLOT_LAST = 4'(SLOT_US - 1);

    // ************************************
    // Widths and reset values
    // ************************************
    localparam int NUM_AC = 4;
    localparam int BK_W   = 10;
    localparam int NAV_W  = 16;
    localparam int TSF_W  = 64;
    localparam int SLP_W  = 24;
    localparam int EVT_N  = 2;
    localparam logic [TSF_W-1:0] TSF_RST  = 64'h0;
    localparam logic [TSF_W-1:0] TBTT_RST = 64'h0;
    localparam logic [NAV_W-1:0] NAV_RST  = 16'h0;

    // ************************************
    // Carriers
    // ************************************
    typedef struct packed {
        logic [NUM_AC-1:0]           bkLoad;
        logic [NUM_AC-1:0]           bkEnable;
        logic [BK_W-1:0]             bkLoadVal;
        logic                        prioLowFirst;
        logic                        navUpdate;
        logic [NAV_W-1:0]            navDuration;
        logic                        tsfLoad;
        logic                        tsfAdvance;
        logic                        tbttArm;
        logic [TSF_W-1:0]            tsfValue;
        logic [31:0]                 tbttInterval;
        logic [EVT_N-1:0][31:0]      evtOffset;
        logic                        sleepLoad;
        logic [SLP_W-1:0]            sleepCount;
        logic                        txScheduled;
        logic                        txUseRifs;
    } wmcat_cmd_type;

    typedef struct packed {
        logic [NUM_AC-1:0] bkZero;
        logic              mediumBusy;
        logic              navBusy;
        logic              ifsDone;
        logic              tbttHit;
        logic [EVT_N-1:0]  evtHit;
        logic              asleep;
    } wmcat_cond_type;

endpackage

//--- wmcat_phy_model.sv
// PHY carrier-sense and slow sleep clock model for the timing bench.
// Assumes burst() is called from the bench just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module wmcat_phy_model (
    input  wire logic clk,
    output var  logic phyBusy,
    output var  logic slowClk
);
    // ************************************
    // Medium and sleep clock
    // ************************************
    int slowRises = 0;

    initial begin
        phyBusy = 1'b0;
        slowClk = 1'b0;
        // Sleep clock runs free, unrelated in phase to clk
        forever begin
            #16001 slowClk = ~slowClk;
            if (slowClk) slowRises++;
        end
    end

    // Activity for n clocks, dropped exactly on an edge
    task automatic burst(input int n);
        @(posedge clk) phyBusy <= 1'b1;
        repeat (n) @(posedge clk);
        phyBusy <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- wmcat_channel_access_bench.sv
// Self-checking bench of the channel-access timing block.
// Assumes the PHY model drives phyBusy and slowClk.
`timescale 1ns/1ps
`default_nettype none

module wmcat_channel_access_bench;
    // ************************************
    // Harness
    // ************************************
    logic                               clk;
    logic                               nrst;
    logic                               phyBusy;
    logic                               slowClk;
    wmcat_pkg::wmcat_cmd_type           cmd;
    logic [wmcat_pkg::NUM_AC-1:0]       acGrant;
    logic                               sifsTrig;
    logic                               rifsTrig;
    logic                               txStart;
    logic                               macClkEn;
    logic                               wakePulse;
    logic                               tbttPulse;
    logic [wmcat_pkg::EVT_N-1:0]        evtPulse;
    logic [wmcat_pkg::TSF_W-1:0]        tsf;
    wmcat_pkg::wmcat_cond_type          cond;
    int                                 errCount = 0;
    int                                 testsRun = 0;
    int                                 grantCnt = 0;

    wmcat_channel_access wmcat_channel_access_i (
        .clk(clk), .nrst(nrst), .phyBusy(phyBusy), .slowClk(slowClk),
        .cmd(cmd), .acGrant(acGrant), .sifsTrig(sifsTrig),
        .rifsTrig(rifsTrig), .txStart(txStart), .macClkEn(macClkEn),
        .wakePulse(wakePulse), .tbttPulse(tbttPulse),
        .evtPulse(evtPulse), .tsf(tsf), .cond(cond)
    );

    wmcat_phy_model wmcat_phy_model_i (
        .clk(clk), .phyBusy(phyBusy), .slowClk(slowClk)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (acGrant != '0) grantCnt <= grantCnt + 1;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("Checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errCount++;
        final_report;
    end

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check("tsf", tsf, '0);
        check("clock enable", macClkEn, 1);
        check("grant", acGrant, 0);
        check("cond", cond, 0);
    endtask

    task automatic wait_grant(input int lim, output logic [3:0] g,
                              output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (acGrant == '0 && k < lim);
        g = acGrant;
    endtask

    // ************************************
    // Scenarios
    // ************************************
    task automatic ifs_case(input logic useRifs, input logic sched,
                            input int gap, input int expTx);
        int kR, kS, kT;
        @(posedge clk);
        cmd.txUseRifs <= useRifs;
        cmd.txScheduled <= sched;
        // Second burst mid-spacing must restart both timers
        if (gap > 0) begin
            wmcat_phy_model_i.burst(10);
            repeat (gap) @(posedge clk);
        end
        wmcat_phy_model_i.burst(10);
        kR = 0;
        kS = 0;
        kT = 0;
        for (int k = 1; k <= 450; k++) begin
            @(posedge clk);
            #1;
            if (rifsTrig === 1'b1 && kR == 0) kR = k;
            if (sifsTrig === 1'b1 && kS == 0) kS = k;
            if (txStart === 1'b1 && kT == 0) kT = k;
        end
        check("rifs delay", kR, wmcat_pkg::RIFS_CYC);
        check("sifs delay", kS, wmcat_pkg::SIFS_CYC);
        check("tx start", kT, expTx);
        check("ifs done", cond.ifsDone, 1);
    endtask

    task automatic bk_case(input logic [3:0] acs, input logic lowFirst,
                           input logic [3:0] exp1, input logic [3:0] exp2);
        logic [3:0] g;
        int         k;
        wmcat_phy_model_i.burst(5);
        cmd.bkLoad <= acs;
        cmd.bkLoadVal <= 10'h001;
        cmd.prioLowFirst <= lowFirst;
        @(posedge clk);
        cmd.bkLoad <= '0;
        cmd.bkEnable <= acs;
        wait_grant(1500, g, k);
        check("first grant", g, exp1);
        @(posedge clk);
        #1;
        check("zero status", cond.bkZero & exp1, exp1);
        wait_grant(500, g, k);
        check("next grant", g, exp2);
        @(posedge clk);
        cmd.bkEnable <= '0;
    endtask

    task automatic bk_hold;
        logic [3:0] g;
        int         k;
        int         g0;
        wmcat_phy_model_i.burst(5);
        cmd.bkLoad <= 4'h1;
        cmd.bkLoadVal <= 10'h003;
        @(posedge clk);
        cmd.bkLoad <= '0;
        cmd.bkEnable <= 4'h1;
        g0 = grantCnt;
        wmcat_phy_model_i.burst(1000);
        check("busy grants", grantCnt - g0, 0);
        wait_grant(2000, g, k);
        check("held grant", g, 4'h1);
        check("three slots", k >= 845 && k <= 1085, 1);
        @(posedge clk);
        cmd.bkEnable <= '0;
    endtask

    task automatic nav_case;
        logic [3:0] g;
        int         k;
        int         g0;
        wmcat_phy_model_i.burst(5);
        repeat (450) @(posedge clk);
        cmd.navUpdate <= 1'b1;
        cmd.navDuration <= 16'h0064;
        cmd.bkLoad <= 4'h1;
        cmd.bkLoadVal <= 10'h001;
        @(posedge clk);
        cmd.navUpdate <= 1'b0;
        cmd.bkLoad <= '0;
        cmd.bkEnable <= 4'h1;
        g0 = grantCnt;
        repeat (750) @(posedge clk);
        // Shorter duration must not shorten the reservation
        cmd.navUpdate <= 1'b1;
        cmd.navDuration <= 16'h000A;
        @(posedge clk);
        cmd.navUpdate <= 1'b0;
        repeat (1624) @(posedge clk);
        #1;
        check("nav busy", cond.navBusy, 1);
        check("nav blocks", grantCnt - g0, 0);
        wait_grant(500, g, k);
        check("grant after nav", g == 4'h1 && k >= 95, 1);
        check("nav clear", cond.navBusy, 0);
        @(posedge clk);
        cmd.bkEnable <= '0;
    endtask

    task automatic tsf_case;
        logic [63:0] t;
        int          k, n0, n1;
        @(posedge clk);
        cmd.tsfLoad <= 1'b1;
        cmd.tsfValue <= 64'h0000_0001_FFFF_FFFF;
        @(posedge clk);
        cmd.tsfLoad <= 1'b0;
        #1;
        check("tsf load", tsf, 64'h0000_0001_FFFF_FFFF);
        repeat (25) @(posedge clk);
        #1;
        check("tsf tick", tsf, 64'h0000_0002_0000_0000);
        t = tsf;
        @(posedge clk);
        cmd.tbttArm <= 1'b1;
        cmd.tsfValue <= t + 64'h2;
        cmd.tbttInterval <= 32'h3;
        @(posedge clk);
        cmd.tbttArm <= 1'b0;
        k = 0;
        n0 = 0;
        n1 = 0;
        while (n1 == 0 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
            if (tbttPulse === 1'b1 && n0 == 0) n0 = k;
            else if (tbttPulse === 1'b1) n1 = k;
        end
        check("tbtt gap", n1 - n0, 75);
        t = tsf;
        @(posedge clk);
        cmd.evtOffset[0] <= t[31:0] + 32'h3;
        cmd.evtOffset[1] <= t[31:0] - 32'h1;
        n0 = 0;
        n1 = 0;
        repeat (150) begin
            @(posedge clk);
            #1;
            n0 += int'(evtPulse[0] === 1'b1);
            n1 += int'(evtPulse[1] === 1'b1);
        end
        check("event hit", n0, 1);
        check("event past", n1, 0);
    endtask

    task automatic sleep_case(input logic [23:0] n);
        logic [63:0] t;
        int          k, r0;
        @(posedge clk);
        cmd.sleepLoad <= 1'b1;
        cmd.sleepCount <= n;
        @(posedge clk);
        cmd.sleepLoad <= 1'b0;
        r0 = wmcat_phy_model_i.slowRises;
        @(posedge clk);
        #1;
        check("clock off", macClkEn, 0);
        check("asleep", cond.asleep, 1);
        k = 0;
        while (wakePulse !== 1'b1 && k < 4000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("wake", wakePulse, 1);
        check("clock on", macClkEn, 1);
        k = wmcat_phy_model_i.slowRises - r0;
        check("sleep ticks", k >= n - 1 && k <= n, 1);
        t = tsf;
        @(posedge clk);
        cmd.tsfAdvance <= 1'b1;
        cmd.tsfValue <= 64'h5;
        @(posedge clk);
        cmd.tsfAdvance <= 1'b0;
        #1;
        check("tsf advance", tsf - t inside {[5:6]}, 1);
    endtask

    initial begin
        nrst = 1'b0;
        cmd = '0;
        do_reset;
        ifs_case(1'b1, 1'b1, 0, wmcat_pkg::RIFS_CYC);
        ifs_case(1'b0, 1'b1, 0, wmcat_pkg::SIFS_CYC);
        ifs_case(1'b0, 1'b0, 200, 0);
        bk_case(4'h1, 1'b1, 4'h1, 4'h0);
        bk_case(4'h6, 1'b1, 4'h2, 4'h4);
        bk_case(4'hA, 1'b0, 4'h8, 4'h2);
        bk_hold;
        nav_case;
        tsf_case;
        sleep_case(24'h000003);
        sleep_case(24'h000002);
        @(posedge clk);
        do_reset;
        final_report;
    end
endmodule

`default_nettype wire
